// [core/gpx_consts.svh]
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH

// Command codes, one per byte register
`define GPX_CMD_IN0    3'h0
`define GPX_CMD_IN1    3'h1
`define GPX_CMD_OUT0   3'h2
`define GPX_CMD_OUT1   3'h3
`define GPX_CMD_INV0   3'h4
`define GPX_CMD_INV1   3'h5
`define GPX_CMD_DIR0   3'h6
`define GPX_CMD_DIR1   3'h7

// Register pair field, command bits [2:1]
`define GPX_PAIR_IN    2'h0
`define GPX_PAIR_OUT   2'h1
`define GPX_PAIR_INV   2'h2
`define GPX_PAIR_DIR   2'h3

// Reset values
`define GPX_OUT_RST    8'hff
`define GPX_INV_RST    8'h00
`define GPX_DIR_RST    8'hff

// Fixed upper address bits; arbitrary value
`define GPX_ADDR_FIXED 5'h10

// Bit counter: last data bit and acknowledge slot
`define GPX_BIT_LAST   4'h7
`define GPX_BIT_ACK    4'h8

// Cycles after reset before synchronised pins are trusted
`define GPX_INIT_DONE  2'h3

`endif

// [core/gpx_pkg.sv]
package gpx_pkg;

  typedef enum logic [2:0] {
    GPX_PH_ADDR,
    GPX_PH_CMD,
    GPX_PH_WDATA,
    GPX_PH_RDATA,
    GPX_PH_IGNORE
  } gpx_phase_t;

endpackage : gpx_pkg

// [core/gpx_sync.sv]
`timescale 1ns/10ps
module gpx_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : gpx_sync

// [core/gpx_regs.sv]
`timescale 1ns/10ps
`include "gpx_consts.svh"
// Summary of operation
// - First byte after a write address loads the register pointer.
// - Codes 0-7 pick input, output, invert, direction registers per port.
// - Input registers show pin levels; writes to them are dropped.
// - Output bits only affect pins whose direction is output.
// - Reading an output register returns stored bits, not pins.
// - Output registers reset to all ones.
// - Invert bit 1 flips the read pin level; 0 leaves it.
// - Invert registers reset to all zeros.
// - Direction bit 1 makes an input, 0 enables the driver.
// - Direction registers reset to all ones, all pins inputs.
// - Output pins are driven high or low from the output bit.
// - Power-on reset sets registers and bus state to defaults.
// - Resetting variant holds registers and bus state while pin low.
// - Other variant: reset pin clears only the bus state.
// - After each written byte the pointer toggles within its pair.
// - Read sends pointed register first, then alternates the pair.
// - Read byte is loaded on the falling edge of the ack clock.
// - Input pin changes raise the interrupt; output pins never do.
// - Interrupt drops when input returns or its port is read.
// - Interrupt clearing is tracked separately for each port.
// - Turning an output into input may raise a false interrupt.
// - Device acks a matching address and each later byte it receives; master acks reads but last.
module gpx_regs #(
  parameter int         W          = 8,
  parameter bit         REG_RESET  = 1'b1,
  parameter logic [4:0] ADDR_FIXED = `GPX_ADDR_FIXED
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe_n_o,
  input  wire logic         addr_select_lo_i,
  input  wire logic         addr_select_hi_i,
  input  wire logic         reset_pin_n_i,
  input  wire logic [W-1:0] port0_pin_i,
  output logic      [W-1:0] port0_pin_o,
  output logic      [W-1:0] port0_pin_oe_n_o,
  input  wire logic [W-1:0] port1_pin_i,
  output logic      [W-1:0] port1_pin_o,
  output logic      [W-1:0] port1_pin_oe_n_o,
  output logic              change_irq_n_o,
  output logic              change_irq_n_oe_n_o
);

  localparam int SW = 2 * W + 7;

  function automatic logic pin_changed(input logic [W-1:0] pin,
                                       input logic [W-1:0] ref_lvl,
                                       input logic [W-1:0] dir);
    return |((pin ^ ref_lvl) & dir);
  endfunction : pin_changed

  // Mclk domain
  logic [SW-1:0]  sync_d;
  logic [SW-1:0]  sync_q;
  logic [W-1:0]   pin_s [2];
  logic           scl_s;
  logic           sda_s;
  logic           sda_d_r;
  logic           addr_lo_s;
  logic           addr_hi_s;
  logic           rst_pin_n_s;
  logic           wr_s;
  logic           rd_s;
  logic           wr_d_r;
  logic           rd_d_r;
  logic           wr_seen;
  logic           rd_seen;
  logic           clr_r;
  logic           pin_rst_r;
  logic           reg_hold;
  logic [W-1:0]   out_r [2];
  logic [W-1:0]   inv_r [2];
  logic [W-1:0]   dir_r [2];
  logic [W-1:0]   ref_r [2];
  logic [1:0]     init_r;
  logic [W-1:0]   rd_snap_r;
  logic [2:0]     rd_addr;
  logic           irq_any;
  logic           irq_n_r;
  logic           sda_o_r;

  // Link domain (scl)
  logic           link_rst_n;
  logic           ptr_rst_n;
  gpx_pkg::gpx_phase_t phase_r;
  logic [3:0]     cnt_r;
  logic [7:0]     sh_r;
  logic [7:0]     byte_nxt;
  logic           ack_pend_r;
  logic           rw_r;
  logic           match;
  logic [2:0]     ptr_r;
  logic [2:0]     wr_addr_r;
  logic [7:0]     wdata_r;
  logic           wr_tgl_r;
  logic           rd_tgl_r;
  logic [7:0]     tx_r;
  logic           sda_oe_n_r;
  logic           rd_more;

  assign sync_d = {reset_pin_n_i, addr_select_hi_i, addr_select_lo_i,
                   sda_i, scl_i, port1_pin_i, port0_pin_i,
                   wr_tgl_r, rd_tgl_r};

  gpx_sync #(.W(SW)) u_sync (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .d_i    (sync_d),
    .q_o    (sync_q)
  );

  assign rd_s        = sync_q[0];
  assign wr_s        = sync_q[1];
  assign pin_s[0]    = sync_q[W+1:2];
  assign pin_s[1]    = sync_q[2*W+1:W+2];
  assign scl_s       = sync_q[2*W+2];
  assign sda_s       = sync_q[2*W+3];
  assign addr_lo_s   = sync_q[2*W+4];
  assign addr_hi_s   = sync_q[2*W+5];
  assign rst_pin_n_s = sync_q[2*W+6];

  assign wr_seen  = wr_s ^ wr_d_r;
  assign rd_seen  = rd_s ^ rd_d_r;
  // Read address is stable for two clocks before its toggle lands
  assign rd_addr  = ptr_r;
  assign reg_hold = pin_rst_r & REG_RESET;

  // Frame edges: clear link logic on start/stop, release once scl low
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_d_r   <= 1'b1;
      clr_r     <= 1'b1;
      pin_rst_r <= 1'b1;
      wr_d_r    <= 1'b0;
      rd_d_r    <= 1'b0;
    end else begin
      sda_d_r   <= sda_s;
      pin_rst_r <= ~rst_pin_n_s;
      wr_d_r    <= wr_s;
      rd_d_r    <= rd_s;
      if (pin_rst_r || (scl_s && (sda_d_r != sda_s)))
        clr_r <= 1'b1;
      else if (!scl_s)
        clr_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int p = 0; p < 2; p++) begin
        out_r[p] <= `GPX_OUT_RST;
        inv_r[p] <= `GPX_INV_RST;
        dir_r[p] <= `GPX_DIR_RST;
      end
    end else if (reg_hold) begin
      for (int p = 0; p < 2; p++) begin
        out_r[p] <= `GPX_OUT_RST;
        inv_r[p] <= `GPX_INV_RST;
        dir_r[p] <= `GPX_DIR_RST;
      end
    end else if (wr_seen) begin
      case (wr_addr_r[2:1])
        `GPX_PAIR_OUT: out_r[wr_addr_r[0]] <= wdata_r;
        `GPX_PAIR_INV: inv_r[wr_addr_r[0]] <= wdata_r;
        `GPX_PAIR_DIR: dir_r[wr_addr_r[0]] <= wdata_r;
        default: ;
      endcase
    end
  end

  assign port0_pin_o      = out_r[0];
  assign port1_pin_o      = out_r[1];
  assign port0_pin_oe_n_o = dir_r[0];
  assign port1_pin_oe_n_o = dir_r[1];

  // Snapshot for the link; also re-arms the change reference per port
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_snap_r <= '0;
    end else if (rd_seen) begin
      case (rd_addr[2:1])
        `GPX_PAIR_IN:  rd_snap_r <= pin_s[rd_addr[0]] ^ inv_r[rd_addr[0]];
        `GPX_PAIR_OUT: rd_snap_r <= out_r[rd_addr[0]];
        `GPX_PAIR_INV: rd_snap_r <= inv_r[rd_addr[0]];
        default:       rd_snap_r <= dir_r[rd_addr[0]];
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_r   <= '0;
      ref_r[0] <= '0;
      ref_r[1] <= '0;
    end else if (reg_hold) begin
      init_r <= '0;
    end else if (init_r != `GPX_INIT_DONE) begin
      init_r   <= init_r + 2'h1;
      ref_r[0] <= pin_s[0];
      ref_r[1] <= pin_s[1];
    end else if (rd_seen && rd_addr[2:1] == `GPX_PAIR_IN) begin
      ref_r[rd_addr[0]] <= pin_s[rd_addr[0]];
    end
  end

  // only input pins compare; follows from the same compare
  assign irq_any = (init_r == `GPX_INIT_DONE) &&
                   (pin_changed(pin_s[0], ref_r[0], dir_r[0]) ||
                    pin_changed(pin_s[1], ref_r[1], dir_r[1]));

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_n_r <= 1'b1;
      sda_o_r <= 1'b0;
    end else begin
      irq_n_r <= ~irq_any;
      sda_o_r <= 1'b0;
    end
  end

  assign change_irq_n_o      = irq_n_r;
  assign change_irq_n_oe_n_o = irq_n_r;
  assign sda_o               = sda_o_r;
  assign sda_oe_n_o          = sda_oe_n_r;

  // Link side: frame logic is cleared by the frame edges, the pointer
  // survives a repeated start and only dies with a reset
  assign link_rst_n = nrst_i & ~clr_r;
  assign ptr_rst_n  = nrst_i & ~pin_rst_r;
  assign byte_nxt   = {sh_r[6:0], sda_i};
  assign match      = byte_nxt[7:1] == {ADDR_FIXED, addr_hi_s, addr_lo_s};
  assign rd_more    = (phase_r == gpx_pkg::GPX_PH_RDATA) && !sda_i;

  always_ff @(posedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase_r    <= gpx_pkg::GPX_PH_ADDR;
      cnt_r      <= '0;
      sh_r       <= '0;
      ack_pend_r <= 1'b0;
      rw_r       <= 1'b0;
    end else if (cnt_r != `GPX_BIT_ACK) begin
      sh_r  <= byte_nxt;
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == `GPX_BIT_LAST) begin
        case (phase_r)
          gpx_pkg::GPX_PH_ADDR:  ack_pend_r <= match;
          gpx_pkg::GPX_PH_CMD:   ack_pend_r <= 1'b1;
          gpx_pkg::GPX_PH_WDATA: ack_pend_r <= 1'b1;
          default:               ack_pend_r <= 1'b0;
        endcase
        if (phase_r == gpx_pkg::GPX_PH_ADDR)
          rw_r <= byte_nxt[0];
      end
    end else begin
      cnt_r      <= '0;
      ack_pend_r <= 1'b0;
      case (phase_r)
        gpx_pkg::GPX_PH_ADDR:
          if (!ack_pend_r)
            phase_r <= gpx_pkg::GPX_PH_IGNORE;
          else if (rw_r)
            phase_r <= gpx_pkg::GPX_PH_RDATA;
          else
            phase_r <= gpx_pkg::GPX_PH_CMD;
        gpx_pkg::GPX_PH_CMD:   phase_r <= gpx_pkg::GPX_PH_WDATA;
        gpx_pkg::GPX_PH_WDATA: phase_r <= gpx_pkg::GPX_PH_WDATA;
        gpx_pkg::GPX_PH_RDATA:
          phase_r <= rd_more ? gpx_pkg::GPX_PH_RDATA
                             : gpx_pkg::GPX_PH_IGNORE;
        default:               phase_r <= gpx_pkg::GPX_PH_IGNORE;
      endcase
    end
  end

  always_ff @(posedge scl_i or negedge ptr_rst_n) begin
    if (!ptr_rst_n) begin
      ptr_r <= '0;
    end else if (cnt_r == `GPX_BIT_LAST &&
                 phase_r == gpx_pkg::GPX_PH_CMD) begin
      ptr_r <= byte_nxt[2:0];
    end else if (cnt_r == `GPX_BIT_ACK &&
                 (phase_r == gpx_pkg::GPX_PH_WDATA || rd_more)) begin
      ptr_r[0] <= ~ptr_r[0];
    end
  end

  // Toggles only reset with power, so a pin reset makes no false edge
  always_ff @(posedge scl_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_tgl_r  <= 1'b0;
      rd_tgl_r  <= 1'b0;
      wdata_r   <= '0;
      wr_addr_r <= '0;
    end else begin
      if (cnt_r == `GPX_BIT_LAST && phase_r == gpx_pkg::GPX_PH_WDATA) begin
        wdata_r   <= byte_nxt;
        wr_addr_r <= ptr_r;
        wr_tgl_r  <= ~wr_tgl_r;
      end
      if (cnt_r == `GPX_BIT_ACK &&
          ((phase_r == gpx_pkg::GPX_PH_ADDR && ack_pend_r && rw_r) ||
           rd_more))
        rd_tgl_r <= ~rd_tgl_r;
    end
  end

  // Transmit on falling scl; needs the snapshot within half a scl period
  always_ff @(negedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_r       <= '0;
      sda_oe_n_r <= 1'b1;
    end else if (cnt_r == `GPX_BIT_ACK) begin
      sda_oe_n_r <= ~ack_pend_r;
    end else if (phase_r == gpx_pkg::GPX_PH_RDATA) begin
      if (cnt_r == '0) begin
        tx_r       <= rd_snap_r;
        sda_oe_n_r <= rd_snap_r[7];
      end else begin
        tx_r       <= {tx_r[6:0], 1'b0};
        sda_oe_n_r <= tx_r[6];
      end
    end else begin
      sda_oe_n_r <= 1'b1;
    end
  end

  property p_hold_defaults;
    @(posedge mclk_i) disable iff (!nrst_i)
      reg_hold |=> (dir_r[0] == `GPX_DIR_RST && out_r[1] == `GPX_OUT_RST
                    && inv_r[0] == `GPX_INV_RST);
  endproperty
  a_hold_defaults: assert property (p_hold_defaults)
    else $error("registers not at defaults during pin reset");

  property p_in_write_dropped;
    @(posedge mclk_i) disable iff (!nrst_i)
      (wr_seen && wr_addr_r[2:1] == `GPX_PAIR_IN) |=>
        ($stable(out_r[0]) && $stable(dir_r[1]) && $stable(inv_r[0]));
  endproperty
  a_in_write_dropped: assert property (p_in_write_dropped)
    else $error("write to input register changed state");

  property p_dir_write;
    @(posedge mclk_i) disable iff (!nrst_i)
      (wr_seen && !reg_hold && wr_addr_r == `GPX_CMD_DIR1) |=>
        port1_pin_oe_n_o == $past(wdata_r);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not reach driver enable");

  property p_in_read;
    @(posedge mclk_i) disable iff (!nrst_i)
      (rd_seen && rd_addr == `GPX_CMD_IN0) |=>
        rd_snap_r == ($past(pin_s[0]) ^ $past(inv_r[0]));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input read not polarity adjusted pin level");

  property p_irq_cause;
    @(posedge mclk_i) disable iff (!nrst_i)
      $fell(change_irq_n_o) |->
        $past(pin_changed(pin_s[0], ref_r[0], dir_r[0]) ||
              pin_changed(pin_s[1], ref_r[1], dir_r[1]), 1);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without input pin change");

  property p_read_rearm;
    @(posedge mclk_i) disable iff (!nrst_i)
      (rd_seen && rd_addr == `GPX_CMD_IN1 && !reg_hold &&
       init_r == `GPX_INIT_DONE) |=>
        (ref_r[1] == $past(pin_s[1]) && $stable(ref_r[0]));
  endproperty
  a_read_rearm: assert property (p_read_rearm)
    else $error("port read did not re-arm only its own port");

  property p_ptr_toggle;
    @(posedge scl_i) disable iff (!ptr_rst_n || !link_rst_n)
      (cnt_r == `GPX_BIT_ACK && phase_r == gpx_pkg::GPX_PH_WDATA) |=>
        ptr_r == {$past(ptr_r[2:1]), ~$past(ptr_r[0])};
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle)
    else $error("pointer did not alternate after write");

  property p_cmd_load;
    @(posedge scl_i) disable iff (!ptr_rst_n || !link_rst_n)
      (cnt_r == `GPX_BIT_LAST && phase_r == gpx_pkg::GPX_PH_CMD) |=>
        ptr_r == $past(byte_nxt[2:0]);
  endproperty
  a_cmd_load: assert property (p_cmd_load)
    else $error("command byte did not load pointer");

  property p_ack_drive;
    @(posedge scl_i) disable iff (!link_rst_n)
      (cnt_r == `GPX_BIT_ACK && ack_pend_r) |-> !sda_oe_n_r;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("acknowledge not driven low");

  property p_addr_miss;
    @(posedge scl_i) disable iff (!link_rst_n)
      (cnt_r == `GPX_BIT_ACK && phase_r == gpx_pkg::GPX_PH_ADDR &&
       !ack_pend_r) |=> phase_r == gpx_pkg::GPX_PH_IGNORE;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign address not ignored");

endmodule : gpx_regs

// [test/gpx_i2c_master.sv]
`timescale 1ns/10ps
module gpx_i2c_master #(
  parameter int QTR = 60
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // Bus idles with both lines released; the clock stands still between frames
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic start_cond;
    sda_pull_o = 1'b0;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    sda_pull_o = 1'b1;
    #(2*QTR);
    scl_o = 1'b0;
    #QTR;
  endtask : start_cond

  task automatic send_bit(input logic b);
    sda_pull_o = ~b;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    scl_o = 1'b0;
    #QTR;
  endtask : send_bit

  // Released line floats high through the pull-up
  task automatic get_bit(output logic b);
    sda_pull_o = 1'b0;
    #QTR;
    scl_o = 1'b1;
    #QTR;
    b = sda_i;
    #QTR;
    scl_o = 1'b0;
    #QTR;
  endtask : get_bit

  // address, command and data bytes, MSB first
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    get_bit(ack);
  endtask : wr_byte

  // acknowledge all but the last byte read
  task automatic rd_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    send_bit(last);
  endtask : rd_byte

  task automatic stop_cond;
    sda_pull_o = 1'b1;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    sda_pull_o = 1'b0;
    #(2*QTR);
  endtask : stop_cond
endmodule : gpx_i2c_master

// [test/test_gpx_regs.sv]
`timescale 1ns/10ps
`include "gpx_consts.svh"
module test_gpx_regs;
  logic       mclk_i;
  logic       nrst_i;
  logic       scl;
  logic       sda_pull;
  logic       sda_w;
  logic       sda_o;
  logic       sda_oe_n;
  logic       a_lo;
  logic       a_hi;
  logic       rst_pin_n;
  logic       irq_n;
  logic       irq_oe_n;
  logic       r_sda_oe_n;
  logic [7:0] r_p0_o;
  logic [4:0] dev_fixed;
  logic [7:0] ext0;
  logic [7:0] ext1;
  logic [7:0] p0_o;
  logic [7:0] p0_oe_n;
  logic [7:0] p1_o;
  logic [7:0] p1_oe_n;
  logic [7:0] lvl0;
  logic [7:0] lvl1;
  int         err_count;
  int         n_compared;

  // Fixed address bits of the second unit; arbitrary value
  localparam logic [4:0] ALT_FIXED = 5'h11;

  // Wired-AND bus with pull-up; pins resolve from each side's enable
  assign sda_w = ~sda_pull & (sda_oe_n | sda_o) & r_sda_oe_n;
  assign lvl0  = (p0_oe_n & ext0) | (~p0_oe_n & p0_o);
  assign lvl1  = (p1_oe_n & ext1) | (~p1_oe_n & p1_o);

  gpx_regs uut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_select_lo_i(a_lo),
    .addr_select_hi_i(a_hi), .reset_pin_n_i(rst_pin_n),
    .port0_pin_i(lvl0), .port0_pin_o(p0_o), .port0_pin_oe_n_o(p0_oe_n),
    .port1_pin_i(lvl1), .port1_pin_o(p1_o), .port1_pin_oe_n_o(p1_oe_n),
    .change_irq_n_o(irq_n), .change_irq_n_oe_n_o(irq_oe_n)
  );

  // Second unit keeps its registers through the reset pin
  gpx_regs #(.REG_RESET(1'b0), .ADDR_FIXED(ALT_FIXED)) uut_r (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_n_o(r_sda_oe_n), .addr_select_lo_i(a_lo),
    .addr_select_hi_i(a_hi), .reset_pin_n_i(rst_pin_n),
    .port0_pin_i(ext0), .port0_pin_o(r_p0_o), .port0_pin_oe_n_o(),
    .port1_pin_i(ext1), .port1_pin_o(), .port1_pin_oe_n_o(),
    .change_irq_n_o(), .change_irq_n_oe_n_o()
  );

  gpx_i2c_master mst (.sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] pin(input logic [7:0] e, o, d);
    return (d & e) | (~d & o);
  endfunction : pin

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic send_hdr(input logic [7:0] cmd);
    logic ack;
    // Keep bus edges off the system clock edges
    #1;
    mst.start_cond();
    mst.wr_byte({dev_fixed, a_hi, a_lo, 1'b0}, ack);
    check({23'h0, ack}, 24'h0, "addr ack");
    mst.wr_byte(cmd, ack);
    check({23'h0, ack}, 24'h0, "cmd ack");
  endtask : send_hdr

  task automatic reg_wr(input logic [7:0] cmd, input logic [23:0] d,
                        input int n);
    logic ack;
    send_hdr(cmd);
    for (int i = 0; i < n; i++) begin
      mst.wr_byte(d[23-8*i -: 8], ack);
      check({23'h0, ack}, 24'h0, "data ack");
    end
    mst.stop_cond();
    repeat (8) @(posedge mclk_i);
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] cmd, input int n,
                        input logic [23:0] exp);
    logic        ack;
    logic [7:0]  b;
    logic [23:0] q;
    q = 24'h0;
    send_hdr(cmd);
    mst.start_cond();
    mst.wr_byte({dev_fixed, a_hi, a_lo, 1'b1}, ack);
    check({23'h0, ack}, 24'h0, "read addr ack");
    for (int i = 0; i < n; i++) begin
      mst.rd_byte(b, i == n - 1);
      q = {q[15:0], b};
    end
    mst.stop_cond();
    check(q, exp, "read data");
    repeat (8) @(posedge mclk_i);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    repeat (10) @(posedge mclk_i);
    check({22'h0, irq_oe_n, irq_n}, {22'h0, exp, exp}, "irq level");
  endtask : irq_chk

  task automatic set_pins(input logic [7:0] e0, input logic [7:0] e1);
    @(posedge mclk_i);
    #1;
    ext0 = e0;
    ext1 = e1;
  endtask : set_pins

  initial begin
    #600_000;
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    logic ack;
    err_count  = 0;
    n_compared = 0;
    dev_fixed  = `GPX_ADDR_FIXED;
    nrst_i     = 1'b0;
    rst_pin_n  = 1'b1;
    a_lo       = 1'b1;
    a_hi       = 1'b0;
    ext0       = 8'ha5;
    ext1       = 8'h3c;
    repeat (6) @(posedge mclk_i);
    #1 nrst_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    check({p0_oe_n, p1_oe_n, p0_o}, 24'hffffff, "reset pins");
    rd_chk(8'h02, 2, 24'h00ffff);
    rd_chk(8'h04, 2, 24'h000000);
    rd_chk(8'h06, 2, 24'h00ffff);
    rd_chk(8'h00, 3, 24'ha53ca5);
    rd_chk(8'h01, 2, 24'h003ca5);
    irq_chk(1'b1);
    reg_wr(8'h00, 24'h5a0000, 1);
    rd_chk(8'h00, 1, 24'h0000a5);
    reg_wr(8'h03, 24'h123456, 3);
    rd_chk(8'h02, 3, 24'h345634);
    rd_chk(8'h00, 2, 24'h00a53c);
    reg_wr(8'h06, 24'h0ff000, 2);
    check({p0_oe_n, p1_oe_n, p0_o}, 24'h0ff034, "drivers");
    rd_chk(8'h00, 2, {8'h0, pin(8'ha5, 8'h34, 8'h0f),
                      pin(8'h3c, 8'h56, 8'hf0)});
    reg_wr(8'h05, 24'hff0000, 1);
    rd_chk(8'h04, 2, 24'h0000ff);
    rd_chk(8'h01, 2, {8'h0, ~pin(8'h3c, 8'h56, 8'hf0),
                      pin(8'ha5, 8'h34, 8'h0f)});
    irq_chk(1'b1);
    set_pins(8'ha4, 8'h3c);
    irq_chk(1'b0);
    set_pins(8'ha5, 8'h3c);
    irq_chk(1'b1);
    // Driven bit: its level cannot move, so no event may appear
    set_pins(8'h25, 8'h3c);
    irq_chk(1'b1);
    set_pins(8'h25, 8'hbc);
    irq_chk(1'b0);
    rd_chk(8'h00, 1, {16'h0, pin(8'h25, 8'h34, 8'h0f)});
    irq_chk(1'b0);
    rd_chk(8'h01, 1, {16'h0, ~pin(8'hbc, 8'h56, 8'hf0)});
    irq_chk(1'b1);
    reg_wr(8'h06, 24'hff0000, 1);
    irq_chk(1'b0);
    rd_chk(8'h00, 1, 24'h000025);
    irq_chk(1'b1);
    #1;
    mst.start_cond();
    mst.wr_byte({`GPX_ADDR_FIXED, a_hi, ~a_lo, 1'b0}, ack);
    check({23'h0, ack}, 24'h1, "foreign nack");
    mst.wr_byte(8'h02, ack);
    mst.wr_byte(8'h00, ack);
    mst.stop_cond();
    rd_chk(8'h02, 1, 24'h000034);
    set_pins(8'h25, 8'hbc);
    a_lo = 1'b0;
    a_hi = 1'b1;
    repeat (8) @(posedge mclk_i);
    rd_chk(8'h07, 1, 24'h0000f0);
    dev_fixed = ALT_FIXED;
    reg_wr(8'h02, 24'h5a0000, 1);
    dev_fixed = `GPX_ADDR_FIXED;
    set_pins(8'h25, 8'hbc);
    rst_pin_n = 1'b0;
    repeat (10) @(posedge mclk_i);
    check({p0_oe_n, p1_oe_n, p1_o}, 24'hffffff, "pin reset");
    check({16'h0, r_p0_o}, 24'h00005a, "kept regs");
    #1 rst_pin_n = 1'b1;
    repeat (8) @(posedge mclk_i);
    dev_fixed = ALT_FIXED;
    rd_chk(8'h02, 1, 24'h00005a);
    dev_fixed = `GPX_ADDR_FIXED;
    rd_chk(8'h04, 2, 24'h000000);
    rd_chk(8'h03, 2, 24'h00ffff);
    reg_wr(8'h06, 24'h000000, 2);
    check({p0_oe_n, p1_oe_n, p1_o}, 24'h0000ff, "all drive");
    set_pins(8'h25, 8'hbc);
    nrst_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    check({p0_oe_n, p1_oe_n, 7'h0, irq_n}, 24'hffff01, "por");
    #1 nrst_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    rd_chk(8'h06, 2, 24'h00ffff);
    stop_test();
  end
endmodule : test_gpx_regs
